// [rtl/fpx_pkg.sv]
`default_nettype none
package fpx_pkg;

    // rounding control encodings
    typedef enum logic [1:0] {
        FPX_RND_NEAREST,
        FPX_RND_DOWN,
        FPX_RND_UP,
        FPX_RND_ZERO
    } fpx_rnd_e;

    // unbounded-exponent width, wide enough for scaled double results
    localparam int unsigned EXP_W = 14;
    localparam int unsigned ADDR_W = 8;

    // exponent limits, unbiased
    localparam logic signed [EXP_W-1:0] EMAX_S  = 14'sh007F;
    localparam logic signed [EXP_W-1:0] EMIN_S  = -14'sh007E;
    localparam logic signed [EXP_W-1:0] EMAX_D  = 14'sh03FF;
    localparam logic signed [EXP_W-1:0] EMIN_D  = -14'sh03FE;
    localparam logic signed [EXP_W-1:0] BIAS_S  = 14'sh007F;
    localparam logic signed [EXP_W-1:0] BIAS_D  = 14'sh03FF;
    localparam logic signed [EXP_W-1:0] SCALE_S = 14'sh00C0;
    localparam logic signed [EXP_W-1:0] SCALE_D = 14'sh0600;

    // biased exponent patterns
    localparam logic [10:0] BEXP_INF_S = 11'h0FF;
    localparam logic [10:0] BEXP_INF_D = 11'h7FF;
    localparam logic [10:0] BEXP_MAX_S = 11'h0FE;
    localparam logic [10:0] BEXP_MAX_D = 11'h7FE;
    localparam logic [51:0] FRAC_ONES  = 52'hF_FFFF_FFFF_FFFF;
    localparam logic [51:0] FRAC_ZERO  = 52'h0_0000_0000_0000;
    localparam int unsigned FRAC_S_LO  = 29;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CLEAR  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_ENABLE = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_LAST   = 8'h10;

    // control fields
    localparam int unsigned CTRL_RND_LO = 0;
    localparam int unsigned CTRL_MSK_O  = 4;
    localparam int unsigned CTRL_MSK_U  = 5;
    localparam int unsigned CTRL_MSK_P  = 6;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0070;

    // status / enable / clear layout
    localparam int unsigned ST_O   = 0;
    localparam int unsigned ST_U   = 1;
    localparam int unsigned ST_P   = 2;
    localparam int unsigned ST_REQ = 3;
    localparam int unsigned ST_W   = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // result from the datapath, rounded with unbounded exponent
    typedef struct packed {
        logic                    dbl;
        logic                    special;
        logic                    zero;
        logic                    sign;
        logic signed [EXP_W-1:0] exp;
        logic [51:0]             frac;
        logic                    inexact_unb;
        logic [63:0]             bounded;
        logic                    inexact_bnd;
    } fpx_in_s;

    // delivered result and flags
    typedef struct packed {
        logic        valid;
        logic [63:0] res;
        logic        overflow_flag_alt;
        logic        underflow_flag;
        logic        precision_flag;
        logic        exc_req;
    } fpx_out_s;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              aw_have;
        logic              w_have;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic [31:0]       ctrl;
        logic [ST_W-1:0]   stat;
        logic [ST_W-1:0]   en;
        logic              irq;
        fpx_out_s          out;
    } fpx_state_s;

endpackage
`default_nettype wire

// [rtl/fpx_result_exc.sv]
// What this block does
// - overflow is flagged when the rounded result is above the largest finite normal of the target precision.
// - masked overflow in round-to-nearest gives a signed infinity and sets overflow and precision flags.
// - masked overflow rounding down gives the largest finite for positive and minus infinity for negative.
// - masked overflow rounding up gives plus infinity for positive and the most negative finite for negative.
// - masked overflow toward zero gives the signed largest finite; masked overflow always sets both flags.
// - unmasked overflow gives the unbounded rounded result scaled down by 2^192 or 2^1536 and sets overflow.
// - on unmasked overflow or underflow the precision flag follows only the inexactness of the scaled result.
// - underflow is flagged when the unbounded rounded result is below the smallest normal of the target.
// - masked underflow gives zero, denormal or normal, with underflow and precision set only if inexact.
// - unmasked underflow gives the unbounded rounded result scaled up by 2^192 or 2^1536 and sets underflow.
// - any result not exactly representable raises the inexact condition, whatever the operation.
// - masked inexact gives the bounded rounded result with the precision flag, beside masked over/underflow.
// - unmasked inexact keeps the masked over/underflow response, else the bounded result with precision set.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module fpx_result_exc (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [fpx_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    // axi4-lite write data
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    // axi4-lite write response
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output logic [1:0]                         s_axi_bresp,
    // axi4-lite read address
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    input  wire logic [fpx_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    // axi4-lite read data
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    // datapath side
    input  wire logic                          in_valid,
    input  wire fpx_pkg::fpx_in_s              in_res,
    output fpx_pkg::fpx_out_s                  out_res,
    // interrupt
    output logic                               irq
);

    fpx_pkg::fpx_state_s s_q;
    fpx_pkg::fpx_state_s s_d;

    // packs sign, biased exponent and fraction into the target format
    function automatic logic [63:0] fpx_pack(
        input logic        dbl,
        input logic        sign,
        input logic [10:0] bexp,
        input logic [51:0] frac
    );
        if (dbl) begin
            fpx_pack = {sign, bexp, frac};
        end else begin
            fpx_pack = {32'h0000_0000, sign, bexp[7:0], frac[51:fpx_pkg::FRAC_S_LO]};
        end
    endfunction

    // byte-lane merge of a write
    function automatic logic [31:0] fpx_merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        fpx_merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                fpx_merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    // exception evaluation signals
    logic                           dbl;
    logic                           sgn;
    logic signed [fpx_pkg::EXP_W-1:0] emax;
    logic signed [fpx_pkg::EXP_W-1:0] emin;
    logic signed [fpx_pkg::EXP_W-1:0] bias;
    logic signed [fpx_pkg::EXP_W-1:0] scale;
    logic signed [fpx_pkg::EXP_W-1:0] sexp;
    logic [10:0]                    bexp_inf;
    logic [10:0]                    bexp_max;
    logic [63:0]                    val_inf;
    logic [63:0]                    val_max;
    logic [63:0]                    bnd;
    logic                           is_ovf;
    logic                           is_unf;
    logic                           msk_o;
    logic                           msk_u;
    logic                           msk_p;
    fpx_pkg::fpx_rnd_e              rnd;
    logic                           use_max;
    fpx_pkg::fpx_out_s              nr;
    logic [fpx_pkg::ST_W-1:0]       clr;
    logic [fpx_pkg::ST_W-1:0]       ev;
    logic                           wr_fire;

    always_comb begin
        s_d = s_q;
        msk_o = s_q.ctrl[fpx_pkg::CTRL_MSK_O];
        msk_u = s_q.ctrl[fpx_pkg::CTRL_MSK_U];
        msk_p = s_q.ctrl[fpx_pkg::CTRL_MSK_P];
        rnd = fpx_pkg::fpx_rnd_e'(s_q.ctrl[fpx_pkg::CTRL_RND_LO +: 2]);

        // format constants for this result
        dbl = in_res.dbl;
        sgn = in_res.sign;
        emax = dbl ? fpx_pkg::EMAX_D : fpx_pkg::EMAX_S;
        emin = dbl ? fpx_pkg::EMIN_D : fpx_pkg::EMIN_S;
        bias = dbl ? fpx_pkg::BIAS_D : fpx_pkg::BIAS_S;
        scale = dbl ? fpx_pkg::SCALE_D : fpx_pkg::SCALE_S;
        bexp_inf = dbl ? fpx_pkg::BEXP_INF_D : fpx_pkg::BEXP_INF_S;
        bexp_max = dbl ? fpx_pkg::BEXP_MAX_D : fpx_pkg::BEXP_MAX_S;
        val_inf = fpx_pack(dbl, sgn, bexp_inf, fpx_pkg::FRAC_ZERO);
        val_max = fpx_pack(dbl, sgn, bexp_max, fpx_pkg::FRAC_ONES);
        // a single result must not leak the datapath's upper word
        bnd = dbl ? in_res.bounded : {32'h0000_0000, in_res.bounded[31:0]};

        // specials and zeros never over/underflow
        is_ovf = !in_res.special && !in_res.zero && (in_res.exp > emax);
        is_unf = !in_res.special && !in_res.zero && (in_res.exp < emin);

        // largest finite replaces infinity when rounding cannot reach it
        use_max = (rnd == fpx_pkg::FPX_RND_ZERO)
                || (rnd == fpx_pkg::FPX_RND_DOWN && !sgn)
                || (rnd == fpx_pkg::FPX_RND_UP && sgn);

        nr = '0;
        nr.valid = in_valid;
        sexp = '0;
        if (is_ovf && !msk_o) begin
            sexp = in_res.exp - scale + bias;
            nr.res = fpx_pack(dbl, sgn, sexp[10:0], in_res.frac);
            nr.overflow_flag_alt = 1'b1;
            nr.precision_flag = in_res.inexact_unb;
        end else if (is_unf && !msk_u) begin
            sexp = in_res.exp + scale + bias;
            nr.res = fpx_pack(dbl, sgn, sexp[10:0], in_res.frac);
            nr.underflow_flag = 1'b1;
            nr.precision_flag = in_res.inexact_unb;
        end else if (is_ovf) begin
            // masked overflow is always inexact
            nr.res = use_max ? val_max : val_inf;
            nr.overflow_flag_alt = 1'b1;
            nr.precision_flag = 1'b1;
        end else if (is_unf) begin
            // the datapath denormalises; a tiny exact result raises nothing
            nr.res = bnd;
            nr.underflow_flag = in_res.inexact_bnd;
            nr.precision_flag = in_res.inexact_bnd;
        end else begin
            nr.res = bnd;
            nr.precision_flag = in_res.inexact_bnd;
        end
        nr.exc_req = (is_ovf && !msk_o)
                   || (is_unf && !msk_u)
                   || (nr.precision_flag && !msk_p);
        if (!in_valid) begin
            nr = '0;
        end
        // last result stays visible; valid is a one-cycle pulse
        s_d.out.valid = nr.valid;
        if (in_valid) begin
            s_d.out = nr;
        end

        // write channel
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        clr = '0;
        wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        if (wr_fire) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = fpx_pkg::RESP_OKAY;
            if (s_q.awaddr == fpx_pkg::REG_CTRL) begin
                s_d.ctrl = fpx_merge(s_q.ctrl, s_q.wdata, s_q.wstrb);
            end else if (s_q.awaddr == fpx_pkg::REG_CLEAR) begin
                clr = s_q.wstrb[0] ? s_q.wdata[fpx_pkg::ST_W-1:0] : '0;
            end else if (s_q.awaddr == fpx_pkg::REG_ENABLE) begin
                if (s_q.wstrb[0]) begin
                    s_d.en = s_q.wdata[fpx_pkg::ST_W-1:0];
                end
            end else if (s_q.awaddr == fpx_pkg::REG_STATUS || s_q.awaddr == fpx_pkg::REG_LAST) begin
                // read-only: write ignored
                s_d.bresp = fpx_pkg::RESP_OKAY;
            end else begin
                s_d.bresp = fpx_pkg::RESP_SLVERR;
            end
        end
        // one write in flight; ready drops while a response is pending
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;

        // read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = fpx_pkg::RESP_OKAY;
            s_d.rdata = '0;
            if (s_axi_araddr == fpx_pkg::REG_CTRL) begin
                s_d.rdata = s_q.ctrl;
            end else if (s_axi_araddr == fpx_pkg::REG_STATUS) begin
                s_d.rdata[fpx_pkg::ST_W-1:0] = s_q.stat;
            end else if (s_axi_araddr == fpx_pkg::REG_CLEAR) begin
                s_d.rdata = '0;
            end else if (s_axi_araddr == fpx_pkg::REG_ENABLE) begin
                s_d.rdata[fpx_pkg::ST_W-1:0] = s_q.en;
            end else if (s_axi_araddr == fpx_pkg::REG_LAST) begin
                s_d.rdata[fpx_pkg::ST_O] = s_q.out.overflow_flag_alt;
                s_d.rdata[fpx_pkg::ST_U] = s_q.out.underflow_flag;
                s_d.rdata[fpx_pkg::ST_P] = s_q.out.precision_flag;
                s_d.rdata[fpx_pkg::ST_REQ] = s_q.out.exc_req;
            end else begin
                s_d.rresp = fpx_pkg::RESP_SLVERR;
            end
        end
        s_d.arready = !s_d.rvalid;

        // sticky status: an event in the clearing cycle survives
        ev = '0;
        ev[fpx_pkg::ST_O] = nr.overflow_flag_alt;
        ev[fpx_pkg::ST_U] = nr.underflow_flag;
        ev[fpx_pkg::ST_P] = nr.precision_flag;
        ev[fpx_pkg::ST_REQ] = nr.exc_req;
        s_d.stat = (s_q.stat & ~clr) | ev;
        s_d.irq = |(s_d.stat & s_d.en);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.ctrl <= fpx_pkg::CTRL_RESET;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign out_res = s_q.out;
    assign irq = s_q.irq;

endmodule
`default_nettype wire

// [sim/fpx_result_exc_properties.sv]
`default_nettype none
module fpx_result_exc_properties (
    // clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // datapath
    input wire logic              in_valid,
    input wire fpx_pkg::fpx_in_s  in_res,
    input wire fpx_pkg::fpx_out_s out_res,
    // read channel
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid
);
    fpx_pkg::fpx_in_s p_q;
    logic             ovf_c;
    logic             unf_c;
    logic             plain_c;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // inputs of the result that out_res now shows
    always_ff @(posedge aclk) begin
        p_q <= in_res;
    end
    assign ovf_c   = p_q.exp > (p_q.dbl ? fpx_pkg::EMAX_D : fpx_pkg::EMAX_S);
    assign unf_c   = p_q.exp < (p_q.dbl ? fpx_pkg::EMIN_D : fpx_pkg::EMIN_S);
    // specials and zeros pass straight through, so they are left out
    assign plain_c = out_res.valid && !p_q.special && !p_q.zero;

    a_valid_latency: assert property (in_valid |=> out_res.valid)
        else $error("result not delivered one cycle after input");
    a_valid_cause: assert property (out_res.valid |-> $past(in_valid))
        else $error("result delivered without input");
    a_ovf_detect: assert property (plain_c |-> out_res.overflow_flag_alt == ovf_c)
        else $error("overflow flag does not match exponent");
    a_unf_detect: assert property (plain_c && !ovf_c |->
        out_res.underflow_flag == (unf_c && (p_q.inexact_bnd || out_res.exc_req)))
        else $error("underflow flag does not match exponent");
    a_ovf_prec: assert property (plain_c && ovf_c && !out_res.exc_req |-> out_res.precision_flag)
        else $error("masked overflow without precision flag");
    a_exact_scaled: assert property (plain_c && out_res.exc_req && !out_res.precision_flag |->
        (ovf_c || unf_c) && !p_q.inexact_unb)
        else $error("request without precision flag on wrong case");
    a_plain_result: assert property (plain_c && !ovf_c && !unf_c |->
        out_res.precision_flag == p_q.inexact_bnd
        && out_res.res == (p_q.dbl ? p_q.bounded : {32'h0000_0000, p_q.bounded[31:0]}))
        else $error("normal result or precision flag wrong");
    a_exc_cause: assert property (out_res.exc_req |->
        out_res.overflow_flag_alt || out_res.underflow_flag || out_res.precision_flag)
        else $error("request raised with no flag");
    a_single_upper: assert property (plain_c && !p_q.dbl |-> out_res.res[63:32] == 32'h0000_0000)
        else $error("single result upper word not zero");
    a_result_hold: assert property (!in_valid |=> $stable(out_res.res) && $stable(out_res.precision_flag))
        else $error("result changed without input");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
endmodule

bind fpx_result_exc fpx_result_exc_properties i_fpx_result_exc_properties (
    .aclk(aclk), .aresetn(aresetn), .in_valid(in_valid), .in_res(in_res), .out_res(out_res),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

// [sim/test_fpx_result_exc.sv]
`default_nettype none
module test_fpx_result_exc;
    timeunit 1ns;
    timeprecision 1ps;

    logic              aclk = 1'b0;
    logic              aresetn, in_valid, irq;
    logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]        s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, ctrl, seed = 32'h0001_6406;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [3:0]        en, st, last;
    fpx_pkg::fpx_in_s  in_res, x;
    fpx_pkg::fpx_out_s out_res, e_prev;
    int                bad_count, cmp_count, m, k;

    always #2 aclk = ~aclk;

    fpx_result_exc i_fpx_result_exc (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .in_valid(in_valid), .in_res(in_res),
        .out_res(out_res), .irq(irq)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // exponents land on both sides of each limit and exactly on it
    function automatic fpx_pkg::fpx_in_s rand_in();
        fpx_pkg::fpx_in_s   v;
        logic [31:0]        r;
        logic signed [13:0] lim;
        r = rnd();
        v = '0;
        v.dbl = r[0];
        v.sign = r[1];
        v.inexact_unb = r[2];
        v.inexact_bnd = r[3];
        v.special = r[22:20] == 3'h7;
        v.zero = r[25:23] == 3'h7;
        v.frac = 52'({rnd(), rnd()});
        v.bounded = {rnd(), rnd()};
        lim = r[0] ? fpx_pkg::EMAX_D : fpx_pkg::EMAX_S;
        case (r[6:4])
            3'h0, 3'h1: v.exp = lim + 14'(r[12:8]) + 14'h1;
            3'h2, 3'h3: v.exp = -lim - 14'(r[12:8]);
            3'h4: v.exp = lim;
            3'h5: v.exp = 14'h1 - lim;
            default: v.exp = 14'(r[15:8]) - 14'h80;
        endcase
        return v;
    endfunction

    function automatic fpx_pkg::fpx_out_s model(input fpx_pkg::fpx_in_s i);
        fpx_pkg::fpx_out_s  o;
        logic               ov, un, uo, uu, big, pl;
        logic signed [13:0] sc, e;
        logic [10:0]        be;
        logic [51:0]        fr;
        o = '0;
        o.valid = 1'b1;
        // specials and zeros pass the bounded value through
        pl = !i.special && !i.zero;
        ov = pl && i.exp > (i.dbl ? fpx_pkg::EMAX_D : fpx_pkg::EMAX_S);
        un = pl && !ov && i.exp < (i.dbl ? fpx_pkg::EMIN_D : fpx_pkg::EMIN_S);
        uo = ov && !ctrl[4];
        uu = un && !ctrl[5];
        sc = i.dbl ? fpx_pkg::SCALE_D : fpx_pkg::SCALE_S;
        e = i.exp + (i.dbl ? fpx_pkg::BIAS_D : fpx_pkg::BIAS_S) + (ov ? -sc : sc);
        big = (ctrl[1:0] == 2'h1 && !i.sign) || (ctrl[1:0] == 2'h2 && i.sign) || ctrl[1:0] == 2'h3;
        be = big ? (i.dbl ? fpx_pkg::BEXP_MAX_D : fpx_pkg::BEXP_MAX_S)
                 : (i.dbl ? fpx_pkg::BEXP_INF_D : fpx_pkg::BEXP_INF_S);
        fr = big ? fpx_pkg::FRAC_ONES : fpx_pkg::FRAC_ZERO;
        if (uo || uu) begin
            be = e[10:0];
            fr = i.frac;
            o.precision_flag = i.inexact_unb;
        end else if (ov) begin
            o.precision_flag = 1'b1;
        end else begin
            o.res = i.dbl ? i.bounded : {32'h0000_0000, i.bounded[31:0]};
            o.underflow_flag = un && i.inexact_bnd;
            o.precision_flag = i.inexact_bnd;
        end
        if (ov || uu) begin
            o.res = i.dbl ? {i.sign, be, fr} : {32'h0000_0000, i.sign, be[7:0], fr[51:29]};
        end
        o.overflow_flag_alt = ov;
        o.underflow_flag = o.underflow_flag || uu;
        o.exc_req = uo || uu || (o.precision_flag && !ctrl[6]);
        return o;
    endfunction

    task automatic chk(input logic [71:0] g, input logic [71:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic finish_test();
        $display("TB: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one register access; w selects write, d is write data or expected read data
    task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int          n;
        bit          ha, hw, hb;
        logic [31:0] q;
        logic [1:0]  rr;
        @(posedge aclk);
        if (w) begin
            s_axi_awvalid <= 1'b1;
            s_axi_awaddr <= a;
            s_axi_wvalid <= 1'b1;
            s_axi_wdata <= d;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_arvalid <= 1'b1;
            s_axi_araddr <= a;
            s_axi_rready <= 1'b1;
        end
        hb = 1'b0;
        for (n = 0; n < 50 && !hb; n++) begin
            @(negedge aclk);
            ha = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = w ? s_axi_bvalid : s_axi_rvalid;
            q = s_axi_rdata;
            rr = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ha && w) s_axi_awvalid <= 1'b0;
            if (ha && !w) s_axi_arvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb && w) s_axi_bready <= 1'b0;
            if (hb && !w) s_axi_rready <= 1'b0;
        end
        if (!hb) begin
            bad_count++;
            finish_test();
        end
        chk(rr, r);
        if (!w) chk(q, d);
    endtask

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, in_valid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        in_res = '0;
        st = '0;
        last = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        acc(1'b0, fpx_pkg::REG_CTRL, fpx_pkg::CTRL_RESET, fpx_pkg::RESP_OKAY);
        acc(1'b0, fpx_pkg::REG_ENABLE, 32'h0, fpx_pkg::RESP_OKAY);
        acc(1'b0, fpx_pkg::REG_LAST, 32'h0, fpx_pkg::RESP_OKAY);
        acc(1'b0, 8'h14, 32'h0, fpx_pkg::RESP_SLVERR);
        acc(1'b1, 8'h14, 32'hFFFF_FFFF, fpx_pkg::RESP_SLVERR);
        // read-only: the write must leave the sticky bits alone
        acc(1'b1, fpx_pkg::REG_STATUS, 32'h0000_000F, fpx_pkg::RESP_OKAY);
        for (m = 0; m < 32; m++) begin
            ctrl = {25'h0, m[4:2], 2'h0, m[1:0]};
            en = 4'(rnd());
            acc(1'b1, fpx_pkg::REG_CTRL, ctrl, fpx_pkg::RESP_OKAY);
            acc(1'b1, fpx_pkg::REG_ENABLE, {28'h0, en}, fpx_pkg::RESP_OKAY);
            acc(1'b0, fpx_pkg::REG_CTRL, ctrl, fpx_pkg::RESP_OKAY);
            // back-to-back results, each checked just after the edge that takes it, one cycle after it is driven
            for (k = 0; k < 13; k++) begin
                @(posedge aclk);
                x = rand_in();
                in_valid <= (k < 12);
                in_res <= x;
                #1;
                if (k > 0) chk(out_res, e_prev);
                e_prev = model(x);
                if (k < 12) st |= {e_prev.exc_req, e_prev.precision_flag, e_prev.underflow_flag, e_prev.overflow_flag_alt};
                if (k < 12) last = {e_prev.exc_req, e_prev.precision_flag, e_prev.underflow_flag, e_prev.overflow_flag_alt};
            end
            acc(1'b0, fpx_pkg::REG_STATUS, {28'h0, st}, fpx_pkg::RESP_OKAY);
            acc(1'b0, fpx_pkg::REG_LAST, {28'h0, last}, fpx_pkg::RESP_OKAY);
            chk(irq, |(st & en));
            acc(1'b1, fpx_pkg::REG_CLEAR, 32'h0000_000F, fpx_pkg::RESP_OKAY);
            st = '0;
            acc(1'b0, fpx_pkg::REG_CLEAR, 32'h0, fpx_pkg::RESP_OKAY);
            acc(1'b0, fpx_pkg::REG_STATUS, 32'h0, fpx_pkg::RESP_OKAY);
            chk(irq, 1'b0);
        end
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge aclk);
        bad_count++;
        finish_test();
    end
endmodule
`default_nettype wire
